// ---- common/sssg_pkg.sv ----
package sssg_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam int          WB_ADR_W       = 16;
    localparam int          WB_DAT_W       = 32;
    localparam logic [15:0] ADR_STATUS     = 16'h2708;
    localparam logic [15:0] ADR_CONTROL    = 16'h270c;
    localparam logic [15:0] ADR_IRQ_STATUS = 16'h2710;
    localparam logic [15:0] ADR_IRQ_MASK   = 16'h2714;
    localparam logic [15:0] ADR_HOST_CMD   = 16'h2718;

    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int         CTL_SAFE_BIT   = 3;
    localparam int         CTL_ENABLE_BIT = 4;
    localparam logic [7:0] CONTROL_RESET  = 8'h10;
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam logic [7:0] HOST_CMD_RESET = 8'h00;

    // ------------------------------------------------------------
    // Transaction status fields
    // ------------------------------------------------------------
    localparam int         ST_ERR_BIT   = 7;
    localparam int         ST_RPAR_BIT  = 6;
    localparam int         ST_WPAR_BIT  = 5;
    localparam int         ST_CNT_MSB   = 4;
    localparam int         ST_CNT_LSB   = 2;
    localparam int         ST_FLASH_BIT = 1;
    localparam int         ST_FRDY_BIT  = 0;
    localparam logic [2:0] SHORT_CNT    = 3'h7;

    // ------------------------------------------------------------
    // Interrupt bits
    // ------------------------------------------------------------
    localparam int         IRQ_W        = 3;
    localparam int         IRQ_DONE_BIT = 0;
    localparam int         IRQ_ERR_BIT  = 1;
    localparam int         IRQ_REJ_BIT  = 2;
    localparam logic [2:0] IRQ_RESET    = 3'h0;

    // ------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------
    localparam int          CMD_READ_BIT   = 7;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [1:0]  TOT_SAT        = 2'h3;
    localparam logic [15:0] SAFE_WIN_BASE  = 16'h0000;
    localparam int          SAFE_WIN_SHIFT = 4;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_CMD     = 5'h02,
        ST_ADDR_HI = 5'h04,
        ST_ADDR_LO = 5'h08,
        ST_DATA    = 5'h10
    } sssg_state_t;

    function automatic logic parity8(input logic [7:0] value);
        parity8 = ^value;
    endfunction

endpackage

// ---- rtl/sssg_shift.sv ----
`timescale 1ns/100ps
module sssg_shift (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       csn,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic [7:0] tx_byte,
    output logic            tx_load,
    output logic            frame_start,
    output logic            frame_end,
    output logic [7:0]      rx_byte,
    output logic            rx_valid,
    output logic            miso,
    output logic            miso_oe
);

    logic       sck_q;
    logic       csn_q;
    logic [2:0] bit_cnt;
    logic [6:0] rx_sr;
    logic [7:0] tx_sr;
    logic       rise;
    logic       fall;

    // Mode 0: sample on rising edge, shift out on falling edge
    assign rise        = sck & ~sck_q & ~csn;
    assign fall        = ~sck & sck_q & ~csn;
    assign frame_start = ~csn & csn_q;
    assign frame_end   = csn & ~csn_q;
    assign tx_load     = frame_start | (fall & (bit_cnt == 3'h0));
    assign miso        = tx_sr[7];
    assign miso_oe     = ~csn;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            sck_q <= 1'b0;
            csn_q <= 1'b1;
        end else begin
            sck_q <= sck;
            csn_q <= csn;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || csn) begin
            bit_cnt <= 3'h0;
            rx_sr   <= 7'h00;
        end else if (rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sr   <= {rx_sr[5:0], mosi};
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            rx_valid <= rise && (bit_cnt == sssg_pkg::BIT_LAST);
            if (rise && (bit_cnt == sssg_pkg::BIT_LAST)) begin
                rx_byte <= {rx_sr, mosi};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            tx_sr <= 8'h00;
        end else if (tx_load) begin
            tx_sr <= tx_byte;
        end else if (fall) begin
            tx_sr <= {tx_sr[6:0], 1'b0};
        end
    end

endmodule

// ---- rtl/sssg_guard.sv ----
`timescale 1ns/100ps
module sssg_guard (
    input  wire logic        safe,
    input  wire logic [15:0] addr,
    output logic             allow
);

    logic in_window;

    // Window is aligned, so only the upper address bits are compared
    assign in_window = addr[15:sssg_pkg::SAFE_WIN_SHIFT]
                    == sssg_pkg::SAFE_WIN_BASE[15:sssg_pkg::SAFE_WIN_SHIFT];
    assign allow     = ~safe | in_window;

endmodule

// ---- rtl/sssg_top.sv ----
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
// Behaviour
// - Safe mode limits writes to command and window
// - Status bit 7 flags device not ready
// - Status bit 6 is parity of sent data
// - Status bit 5 is parity of received bytes
// - Bits 4-2 give data count, short gives 111
// - Bit 1 shows flash mode, zero without test
// - Bit 0 shows flash ready for next write
// - Status holds results of previous transaction
// - Command byte captured into readable register
// - Port works only when enabled and pins free
module sssg_top (
    input  wire logic        CLOCK,
    input  wire logic        RESETN,
    input  wire logic [15:0] WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic        WB_WE_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_CYC_I,
    output logic             WB_ACK_O,
    output logic             IRQ,
    input  wire logic        SPI_CSN,
    input  wire logic        SPI_SCK,
    input  wire logic        SPI_MOSI,
    output logic             SPI_MISO,
    output logic             SPI_MISO_OE,
    input  wire logic        SEGMENT_PIN_ASSIGN,
    input  wire logic        TEST_PIN,
    input  wire logic        FLASH_PROG_ACTIVE,
    input  wire logic        FLASH_READY,
    output logic      [15:0] MEM_ADDR,
    output logic      [7:0]  MEM_WDATA,
    output logic             MEM_WE,
    output logic             MEM_RE,
    input  wire logic [7:0]  MEM_RDATA,
    input  wire logic        MEM_RVALID,
    input  wire logic        MEM_READY
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sssg_pkg::sssg_state_t state;

    logic [7:0]          control;
    logic [7:0]          status;
    logic [7:0]          host_cmd;
    logic [2:0]          irq_status;
    logic [2:0]          irq_mask;
    logic [2:0]          irq_event;
    logic                port_on;
    logic                csn_eff;
    logic                tx_load;
    logic                frame_start;
    logic                frame_end;
    logic [7:0]          rx_byte;
    logic                rx_valid;
    logic [7:0]          tx_byte;
    logic [7:0]          tx_cur;
    logic                is_read;
    logic [7:0]          addr_hi;
    logic                rd_pend;
    logic [7:0]          rd_buf;
    logic                rd_full;
    logic                wr_allow;
    logic                wr_event;
    logic                mem_step;
    logic                rd_starve;
    logic                err;
    logic                rejected;
    logic                rpar;
    logic                wpar;
    logic [2:0]          data_cnt;
    logic                data_seen;
    logic [1:0]          tot_cnt;
    logic [2:0]          next_cnt;
    logic                wb_req;
    logic                wb_wr;
    logic [31:0]         next_rdata;
    logic [2:0]          next_irq;

    // ------------------------------------------------------------
    // Pin gating
    // ------------------------------------------------------------
    // A disabled port looks like an idle bus, so an enable drop
    // mid-frame ends the frame cleanly instead of hanging it.
    assign port_on = control[sssg_pkg::CTL_ENABLE_BIT]
                   & ~SEGMENT_PIN_ASSIGN;
    assign csn_eff = SPI_CSN | ~port_on;

    sssg_shift u_shift (
        .clock       (CLOCK),
        .resetn      (RESETN),
        .csn         (csn_eff),
        .sck         (SPI_SCK),
        .mosi        (SPI_MOSI),
        .tx_byte     (tx_byte),
        .tx_load     (tx_load),
        .frame_start (frame_start),
        .frame_end   (frame_end),
        .rx_byte     (rx_byte),
        .rx_valid    (rx_valid),
        .miso        (SPI_MISO),
        .miso_oe     (SPI_MISO_OE)
    );

    sssg_guard u_guard (
        .safe  (control[sssg_pkg::CTL_SAFE_BIT]),
        .addr  (MEM_ADDR),
        .allow (wr_allow)
    );

    // ------------------------------------------------------------
    // Outgoing byte selection
    // ------------------------------------------------------------
    // First byte of each frame carries the previous result
    always_comb begin
        tx_byte = 8'h00;
        if (state == sssg_pkg::ST_IDLE) begin
            tx_byte = status;
        end else if (state == sssg_pkg::ST_DATA && is_read && rd_full) begin
            tx_byte = rd_buf;
        end
    end

    assign wr_event  = rx_valid && state == sssg_pkg::ST_DATA && !is_read;
    assign rd_starve = tx_load && state == sssg_pkg::ST_DATA
                    && is_read && !rd_full;

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            state   <= sssg_pkg::ST_IDLE;
            is_read <= 1'b0;
            addr_hi <= 8'h00;
        end else if (frame_end) begin
            state <= sssg_pkg::ST_IDLE;
        end else if (frame_start) begin
            state <= sssg_pkg::ST_CMD;
        end else if (rx_valid) begin
            case (state)
                sssg_pkg::ST_CMD: begin
                    is_read <= rx_byte[sssg_pkg::CMD_READ_BIT];
                    state   <= sssg_pkg::ST_ADDR_HI;
                end
                sssg_pkg::ST_ADDR_HI: begin
                    addr_hi <= rx_byte;
                    state   <= sssg_pkg::ST_ADDR_LO;
                end
                sssg_pkg::ST_ADDR_LO: begin
                    state <= sssg_pkg::ST_DATA;
                end
                sssg_pkg::ST_DATA: begin
                    state <= sssg_pkg::ST_DATA;
                end
                default: begin
                    state <= sssg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Command byte is always kept, safe mode or not
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            host_cmd <= sssg_pkg::HOST_CMD_RESET;
        end else if (rx_valid && state == sssg_pkg::ST_CMD) begin
            host_cmd <= rx_byte;
        end
    end

    // ------------------------------------------------------------
    // Memory side
    // ------------------------------------------------------------
    // Address advances on every attempted access, refused or not,
    // so the master's view of the stream stays aligned. The step
    // lags the strobe by a cycle so each pulse carries its own address.
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            MEM_ADDR <= 16'h0000;
        end else if (rx_valid && state == sssg_pkg::ST_ADDR_LO) begin
            MEM_ADDR <= {addr_hi, rx_byte};
        end else if (mem_step) begin
            MEM_ADDR <= MEM_ADDR + 16'h0001;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            MEM_WE    <= 1'b0;
            MEM_WDATA <= 8'h00;
            mem_step  <= 1'b0;
        end else begin
            MEM_WE <= wr_event && wr_allow && MEM_READY;
            mem_step <= wr_event || rd_pend;
            if (wr_event) begin
                MEM_WDATA <= rx_byte;
            end
        end
    end

    // Prefetch one byte ahead; the master must leave enough time
    // between bytes for the memory to answer.
    always_ff @(posedge CLOCK) begin
        if (!RESETN || frame_end) begin
            rd_pend <= 1'b0;
        end else if ((rx_valid && state == sssg_pkg::ST_ADDR_LO
                      && is_read) || (tx_load && is_read
                      && state == sssg_pkg::ST_DATA)) begin
            rd_pend <= 1'b1;
        end else begin
            rd_pend <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            MEM_RE <= 1'b0;
        end else begin
            MEM_RE <= rd_pend && MEM_READY;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN || frame_start) begin
            rd_buf  <= 8'h00;
            rd_full <= 1'b0;
        end else if (MEM_RVALID) begin
            rd_buf  <= MEM_RDATA;
            rd_full <= 1'b1;
        end else if (tx_load && state == sssg_pkg::ST_DATA) begin
            rd_full <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Per-frame accumulators
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            tx_cur <= 8'h00;
        end else if (tx_load) begin
            tx_cur <= tx_byte;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN || frame_start) begin
            err <= 1'b0;
        end else if (rd_starve || (rd_pend && !MEM_READY)
                     || (wr_event && wr_allow && !MEM_READY)) begin
            err <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN || frame_start) begin
            rejected <= 1'b0;
        end else if (wr_event && !wr_allow) begin
            rejected <= 1'b1;
        end
    end

    // Sent parity counts data bytes only, never the status byte
    always_ff @(posedge CLOCK) begin
        if (!RESETN || frame_start) begin
            rpar <= 1'b0;
        end else if (rx_valid && state == sssg_pkg::ST_DATA && is_read) begin
            rpar <= rpar ^ sssg_pkg::parity8(tx_cur);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN || frame_start) begin
            wpar <= 1'b0;
        end else if (rx_valid) begin
            wpar <= wpar ^ sssg_pkg::parity8(rx_byte);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN || frame_start) begin
            data_cnt  <= 3'h0;
            data_seen <= 1'b0;
            tot_cnt   <= 2'h0;
        end else if (rx_valid) begin
            if (state == sssg_pkg::ST_DATA) begin
                data_cnt  <= data_cnt + 3'h1;
                data_seen <= 1'b1;
            end
            if (tot_cnt != sssg_pkg::TOT_SAT) begin
                tot_cnt <= tot_cnt + 2'h1;
            end
        end
    end

    // A frame with no complete byte reports a count of zero
    always_comb begin
        next_cnt = data_cnt;
        if (!data_seen && tot_cnt != 2'h0) begin
            next_cnt = sssg_pkg::SHORT_CNT;
        end
    end

    // ------------------------------------------------------------
    // Transaction status
    // ------------------------------------------------------------
    // Flash bits are sampled at frame end, so a master polling for
    // readiness needs one extra frame to see a change.
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            status <= sssg_pkg::STATUS_RESET;
        end else if (frame_end) begin
            status[sssg_pkg::ST_ERR_BIT]  <= err;
            status[sssg_pkg::ST_RPAR_BIT] <= rpar;
            status[sssg_pkg::ST_WPAR_BIT] <= wpar;
            status[sssg_pkg::ST_CNT_MSB:sssg_pkg::ST_CNT_LSB] <= next_cnt;
            status[sssg_pkg::ST_FLASH_BIT] <= FLASH_PROG_ACTIVE
                                            & TEST_PIN;
            status[sssg_pkg::ST_FRDY_BIT]  <= FLASH_PROG_ACTIVE & TEST_PIN
                                            & FLASH_READY;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wb_wr  = wb_req & WB_WE_I & WB_SEL_I[0];

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= wb_req;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (WB_ADR_I)
            sssg_pkg::ADR_STATUS:     next_rdata[7:0] = status;
            sssg_pkg::ADR_CONTROL:    next_rdata[7:0] = control;
            sssg_pkg::ADR_IRQ_STATUS: next_rdata[2:0] = irq_status;
            sssg_pkg::ADR_IRQ_MASK:   next_rdata[2:0] = irq_mask;
            sssg_pkg::ADR_HOST_CMD:   next_rdata[7:0] = host_cmd;
            default:                  next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (wb_req && !WB_WE_I) begin
            WB_DAT_O <= next_rdata;
        end
    end

    // Only enable and safe bits are writable; the rest read zero
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            control <= sssg_pkg::CONTROL_RESET;
        end else if (wb_wr && WB_ADR_I == sssg_pkg::ADR_CONTROL) begin
            control <= 8'h00;
            control[sssg_pkg::CTL_SAFE_BIT] <=
                WB_DAT_I[sssg_pkg::CTL_SAFE_BIT];
            control[sssg_pkg::CTL_ENABLE_BIT] <=
                WB_DAT_I[sssg_pkg::CTL_ENABLE_BIT];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            irq_mask <= sssg_pkg::IRQ_RESET;
        end else if (wb_wr && WB_ADR_I == sssg_pkg::ADR_IRQ_MASK) begin
            irq_mask <= WB_DAT_I[2:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irq_event[sssg_pkg::IRQ_DONE_BIT] = frame_end;
    assign irq_event[sssg_pkg::IRQ_ERR_BIT]  = frame_end & err;
    assign irq_event[sssg_pkg::IRQ_REJ_BIT]  = frame_end & rejected;

    // Set beats write-one-to-clear in the same cycle
    always_comb begin
        next_irq = irq_status;
        if (wb_wr && WB_ADR_I == sssg_pkg::ADR_IRQ_STATUS) begin
            next_irq = irq_status & ~WB_DAT_I[2:0];
        end
        next_irq = next_irq | irq_event;
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            irq_status <= sssg_pkg::IRQ_RESET;
        end else begin
            irq_status <= next_irq;
        end
    end

    assign IRQ = |(irq_status & irq_mask);

endmodule

// ---- tb/sssg_props.sv ----
`timescale 1ns/100ps
module sssg_props (
    input wire logic        CLOCK,
    input wire logic        RESETN,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic        WB_WE_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_CYC_I,
    input wire logic        WB_ACK_O,
    input wire logic        IRQ,
    input wire logic        SPI_CSN,
    input wire logic        SPI_MISO_OE,
    input wire logic        SEGMENT_PIN_ASSIGN,
    input wire logic [15:0] MEM_ADDR,
    input wire logic        MEM_WE,
    input wire logic        MEM_RE
);
    logic safe_q;
    logic en_q;
    // ---
    // Control mirror, may lag a cycle; no frame runs that close
    // ---
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            safe_q <= 1'b0;
            en_q   <= 1'b1;
        end else if (WB_ACK_O && WB_WE_I && WB_SEL_I[0]
                     && WB_ADR_I == sssg_pkg::ADR_CONTROL) begin
            safe_q <= WB_DAT_I[sssg_pkg::CTL_SAFE_BIT];
            en_q   <= WB_DAT_I[sssg_pkg::CTL_ENABLE_BIT];
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack long");
    property p_oe_seg;
        SEGMENT_PIN_ASSIGN && $past(SEGMENT_PIN_ASSIGN) |-> !SPI_MISO_OE;
    endproperty
    a_oe_seg: assert property (p_oe_seg) else $error("oe on seg");
    property p_oe_idle; SPI_CSN && $past(SPI_CSN) |-> !SPI_MISO_OE; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
    property p_oe_on;
        !SPI_CSN && !$past(SPI_CSN, 2) && en_q && !SEGMENT_PIN_ASSIGN
            && !$past(SEGMENT_PIN_ASSIGN, 2) |-> SPI_MISO_OE;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe off");
    property p_safe;
        MEM_WE && safe_q |-> MEM_ADDR[15:4] == 12'h000;
    endproperty
    a_safe: assert property (p_safe) else $error("safe write");
    property p_we; MEM_WE |=> !MEM_WE; endproperty
    a_we: assert property (p_we) else $error("we long");
    property p_re; MEM_RE |=> !MEM_RE; endproperty
    a_re: assert property (p_re) else $error("re long");
    c_we: cover property (MEM_WE);
    c_re: cover property (MEM_RE);
    c_irq: cover property (IRQ);
    c_safe: cover property (safe_q && !SPI_CSN);
endmodule

// ---- tb/sssg_master.sv ----
`timescale 1ns/100ps
module sssg_master (
    input wire logic CLOCK,
    input wire logic SPI_MISO,
    output logic     SPI_CSN,
    output logic     SPI_SCK,
    output logic     SPI_MOSI
);
    // ---
    // Frame driver, serial clock idles low between frames
    // ---
    initial begin
        SPI_CSN = 1'b1;
        SPI_SCK = 1'b0;
        SPI_MOSI = 1'b0;
    end
    task automatic xfer(input logic [31:0] d, input int n, input int hp,
                        output logic [7:0] rx0, output logic [7:0] rxl);
        logic [7:0] r;
        r = 8'h00;
        SPI_CSN <= 1'b0;
        for (int i = 0; i < n * 8; i++) begin
            SPI_MOSI <= d[31 - i];
            repeat (hp) @(posedge CLOCK);
            SPI_SCK <= 1'b1;
            r = {r[6:0], SPI_MISO};
            if (i == 7) rx0 = r;
            repeat (hp) @(posedge CLOCK);
            SPI_SCK <= 1'b0;
        end
        rxl = r;
        repeat (hp) @(posedge CLOCK);
        SPI_CSN <= 1'b1;
        // Released line shows no stale level
        SPI_MOSI <= ~SPI_MOSI;
        repeat (4 * hp) @(posedge CLOCK);
    endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    logic        CLOCK = 1'b0;
    logic        RESETN, WB_WE_I, WB_STB_I, WB_CYC_I, WB_ACK_O, IRQ;
    logic        SPI_CSN, SPI_SCK, SPI_MOSI, SPI_MISO, SPI_MISO_OE;
    logic        SEGMENT_PIN_ASSIGN, TEST_PIN, FLASH_PROG_ACTIVE, FLASH_READY;
    logic        MEM_WE, MEM_RE, MEM_RVALID, MEM_READY;
    logic [3:0]  WB_SEL_I;
    logic [7:0]  MEM_WDATA, MEM_RDATA, rx0, rxl;
    logic [15:0] WB_ADR_I, MEM_ADDR;
    logic [23:0] wr_last;
    logic [31:0] WB_DAT_I, WB_DAT_O, rd;
    int          fail_count, cmp_count, cyc, we_count, we_base;

    sssg_top    sssg_top_i (.*);
    sssg_master sssg_master_i (.*);

    always #2 CLOCK = ~CLOCK;

    // ---
    // Memory answers each read one cycle later
    // ---
    always @(posedge CLOCK) begin
        MEM_RVALID <= MEM_RE;
        cyc <= cyc + 1;
        if (MEM_WE) begin
            we_count <= we_count + 1;
            wr_last <= {MEM_ADDR, MEM_WDATA};
        end
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            results();
        end
    end

    task automatic results();
        $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
        @(posedge CLOCK);
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_SEL_I} <= {2'h3, w, 4'h1};
        {WB_ADR_I, WB_DAT_I} <= {a, d};
        @(posedge CLOCK);
        while (WB_ACK_O !== 1'b1) @(posedge CLOCK);
        rd = WB_DAT_O;
        {WB_CYC_I, WB_STB_I} <= 2'h0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [31:0] e, string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    initial begin
        {RESETN, WB_WE_I, WB_STB_I, WB_CYC_I, SEGMENT_PIN_ASSIGN} = '0;
        {WB_ADR_I, WB_DAT_I, WB_SEL_I} = '0;
        {TEST_PIN, FLASH_PROG_ACTIVE, FLASH_READY, MEM_READY} = 4'hf;
        MEM_RDATA = 8'h5b;
        repeat (2) @(posedge CLOCK);
        RESETN <= 1'b1;
        rdc(sssg_pkg::ADR_STATUS, 32'h00, "status");
        rdc(sssg_pkg::ADR_CONTROL, 32'h10, "control");
        rdc(sssg_pkg::ADR_HOST_CMD, 32'h00, "host_cmd");
        rdc(16'h2700, 32'h00, "unmapped");
        wb(1'b1, sssg_pkg::ADR_IRQ_MASK, 32'h07);
        sssg_master_i.xfer(32'h000003a5, 4, 10, rx0, rxl);
        chk("first_byte", 32'h00, rx0);
        chk("mem_write", 32'h0003a5, wr_last);
        rdc(sssg_pkg::ADR_STATUS, 32'h07, "status");
        chk("irq", 32'h1, IRQ);
        wb(1'b1, sssg_pkg::ADR_IRQ_MASK, 32'h00);
        chk("irq", 32'h0, IRQ);
        wb(1'b1, sssg_pkg::ADR_IRQ_STATUS, 32'h01);
        rdc(sssg_pkg::ADR_IRQ_STATUS, 32'h00, "irq_status");
        TEST_PIN <= 1'b0;
        sssg_master_i.xfer(32'h01000000, 1, 6, rx0, rxl);
        chk("first_byte", 32'h07, rx0);
        rdc(sssg_pkg::ADR_STATUS, 32'h3c, "status");
        rdc(sssg_pkg::ADR_HOST_CMD, 32'h01, "host_cmd");
        {TEST_PIN, FLASH_READY} <= 2'h2;
        sssg_master_i.xfer(32'h80000500, 4, 6, rx0, rxl);
        chk("first_byte", 32'h3c, rx0);
        chk("read_byte", 32'h5b, rxl);
        rdc(sssg_pkg::ADR_STATUS, 32'h66, "status");
        {FLASH_READY, MEM_READY} <= 2'h2;
        sssg_master_i.xfer(32'h00000401, 4, 6, rx0, rxl);
        rdc(sssg_pkg::ADR_STATUS, 32'h87, "status");
        rdc(sssg_pkg::ADR_IRQ_STATUS, 32'h03, "irq_status");
        MEM_READY <= 1'b1;
        wb(1'b1, sssg_pkg::ADR_IRQ_STATUS, 32'h07);
        wb(1'b1, sssg_pkg::ADR_CONTROL, 32'h18);
        we_base = we_count;
        sssg_master_i.xfer(32'h00001011, 4, 6, rx0, rxl);
        chk("refused", we_base, we_count);
        rdc(sssg_pkg::ADR_IRQ_STATUS, 32'h05, "irq_status");
        sssg_master_i.xfer(32'h00000f22, 4, 6, rx0, rxl);
        chk("mem_write", 32'h000f22, wr_last);
        sssg_master_i.xfer(32'h44000000, 1, 6, rx0, rxl);
        rdc(sssg_pkg::ADR_HOST_CMD, 32'h44, "host_cmd");
        for (int k = 0; k < 2; k++) begin
            SEGMENT_PIN_ASSIGN <= (k == 0);
            wb(1'b1, sssg_pkg::ADR_CONTROL, (k == 0) ? 32'h10 : 32'h00);
            sssg_master_i.xfer(32'h55000000, 1, 6, rx0, rxl);
            rdc(sssg_pkg::ADR_HOST_CMD, 32'h44, "host_cmd");
        end
        results();
    end
endmodule

bind sssg_top sssg_props sssg_props_i (.*);
